// ===== logic/iosd_pkg.sv
package iosd_pkg;

    // Address spaces seen by the core.
    localparam int unsigned IO_COUNT      = 64;
    localparam logic [7:0]  DM_IO_OFFSET  = 8'h20;
    localparam logic [7:0]  DM_EXT_BASE   = 8'h60;
    localparam logic [5:0]  BIT_SPACE_TOP = 6'h1f;
    localparam logic [7:0]  RESET_VALUE   = 8'h00;

    // I/O offsets of the implemented registers.
    localparam logic [5:0] PORT_B_INPUT_PINS      = 6'h03;
    localparam logic [5:0] PORT_B_DIRECTION       = 6'h04;
    localparam logic [5:0] PORT_B_OUTPUT_LATCH    = 6'h05;
    localparam logic [5:0] PORT_C_INPUT_PINS      = 6'h06;
    localparam logic [5:0] PORT_C_DIRECTION       = 6'h07;
    localparam logic [5:0] PORT_C_OUTPUT_LATCH    = 6'h08;
    localparam logic [5:0] PORT_D_INPUT_PINS      = 6'h09;
    localparam logic [5:0] PORT_D_DIRECTION       = 6'h0a;
    localparam logic [5:0] PORT_D_OUTPUT_LATCH    = 6'h0b;
    localparam logic [5:0] TIMER0_EVENT_FLAGS     = 6'h15;
    localparam logic [5:0] TIMER1_EVENT_FLAGS     = 6'h16;
    localparam logic [5:0] TIMER2_EVENT_FLAGS     = 6'h17;
    localparam logic [5:0] PIN_CHANGE_FLAGS       = 6'h1b;
    localparam logic [5:0] EXTERNAL_IRQ_FLAGS     = 6'h1c;
    localparam logic [5:0] EXTERNAL_IRQ_MASK      = 6'h1d;
    localparam logic [5:0] GENERAL_SCRATCH_0      = 6'h1e;
    localparam logic [5:0] EEPROM_CONTROL         = 6'h1f;
    localparam logic [5:0] EEPROM_DATA            = 6'h20;
    localparam logic [5:0] EEPROM_ADDRESS_LOW     = 6'h21;
    localparam logic [5:0] EEPROM_ADDRESS_HIGH    = 6'h22;
    localparam logic [5:0] TIMER_PRESCALER_SYNC   = 6'h23;
    localparam logic [5:0] TIMER0_CONTROL_A       = 6'h24;
    localparam logic [5:0] TIMER0_CONTROL_B       = 6'h25;
    localparam logic [5:0] TIMER0_COUNT           = 6'h26;
    localparam logic [5:0] TIMER0_COMPARE_A       = 6'h27;
    localparam logic [5:0] TIMER0_COMPARE_B       = 6'h28;
    localparam logic [5:0] GENERAL_SCRATCH_1      = 6'h2a;
    localparam logic [5:0] GENERAL_SCRATCH_2      = 6'h2b;
    localparam logic [5:0] SERIAL_PERIPH_CONTROL  = 6'h2c;
    localparam logic [5:0] SERIAL_PERIPH_STATUS   = 6'h2d;
    localparam logic [5:0] SERIAL_PERIPH_DATA     = 6'h2e;
    localparam logic [5:0] COMPARATOR_CTRL_STATUS = 6'h30;

    // Field layouts: writable, write-one-to-clear and hardware-driven bits.
    localparam logic [7:0] MASK_FULL       = 8'hff;
    localparam logic [7:0] MASK_PORT_C     = 8'h7f;
    localparam logic [7:0] W1C_TIMER0      = 8'h07;
    localparam logic [7:0] W1C_TIMER1      = 8'h27;
    localparam logic [7:0] W1C_TIMER2      = 8'h07;
    localparam logic [7:0] W1C_PIN_CHANGE  = 8'h07;
    localparam logic [7:0] W1C_EXT_IRQ     = 8'h03;
    localparam logic [7:0] W1C_COMPARATOR  = 8'h10;
    localparam logic [7:0] RW_EXT_IRQ_MASK = 8'h03;
    localparam logic [7:0] RW_EEPROM_CTRL  = 8'h3f;
    localparam logic [7:0] RW_PRESCALER    = 8'h83;
    localparam logic [7:0] RW_TIMER0_A     = 8'hf3;
    localparam logic [7:0] RW_TIMER0_B     = 8'hcf;
    localparam logic [7:0] RW_SPI_STATUS   = 8'h01;
    localparam logic [7:0] RW_COMPARATOR   = 8'hcf;
    localparam int unsigned SPI_FLAG_LSB   = 6;
    localparam int unsigned CMP_OUT_BIT    = 5;

endpackage : iosd_pkg

// ===== logic/iosd_io_space.sv
`timescale 1ns/1ps
// Contract
// - Single-bit set and clear requests act directly on any register at I/O address 0x00 to 0x1F.
// - Skip-if-bit-one and skip-if-bit-zero tests read one bit of a register in that low range.
// - Status flags marked write-one-to-clear clear on a written one and ignore a written zero.
// - A single-bit set or clear changes only the addressed bit, never a neighbouring flag.
// - Short I/O input and output requests use I/O addresses 0x00 through 0x3F only.
// - Each I/O register also answers in data space at its I/O address plus 0x20.
// - Exactly 64 locations are reachable by short I/O requests through a six-bit address.
// - Data addresses 0x60 to 0xFF are reached only by loads and stores, never by short I/O.
module iosd_io_space (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Short I/O transfers
    input  wire logic         io_rd,
    input  wire logic         io_wr,
    input  wire logic [5:0]   io_addr,
    input  wire logic [7:0]   io_wdata,
    // Data space loads and stores
    input  wire logic         dm_rd,
    input  wire logic         dm_wr,
    input  wire logic [7:0]   dm_addr,
    input  wire logic [7:0]   dm_wdata,
    // Single-bit set, clear and skip tests
    input  wire logic         set_single_bit_instr,
    input  wire logic         clear_single_bit_instr,
    input  wire logic         skip_if_io_bit_one,
    input  wire logic         skip_if_io_bit_zero,
    input  wire logic [4:0]   bit_addr,
    input  wire logic [2:0]   bit_sel,
    // Answers to the core
    output logic [7:0]        rdata,
    output logic              rd_valid,
    output logic              skip_valid,
    output logic              skip_taken,
    // Extended area forwarded to the outer register logic
    output logic              ext_rd,
    output logic              ext_wr,
    output logic [7:0]        ext_addr,
    output logic [7:0]        ext_wdata,
    // Peripheral side
    input  wire logic [23:0]  port_pins,
    input  wire logic [7:0]   tmr0_flag_set,
    input  wire logic [7:0]   tmr1_flag_set,
    input  wire logic [7:0]   tmr2_flag_set,
    input  wire logic [7:0]   pin_change_set,
    input  wire logic [7:0]   ext_irq_set,
    input  wire logic         cmp_flag_set,
    input  wire logic         cmp_output,
    input  wire logic [1:0]   spi_flags,
    output logic [511:0]      io_image
);

    logic [7:0]  regs_reg [0:iosd_pkg::IO_COUNT-1];
    logic [7:0]  regs_next [0:iosd_pkg::IO_COUNT-1];
    logic [23:0] pin_meta_reg;
    logic [23:0] pin_sync_reg;
    logic [1:0]  spi_meta_reg;
    logic [1:0]  spi_sync_reg;
    logic        cmp_meta_reg;
    logic        cmp_sync_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        rd_valid_reg;
    logic        rd_valid_next;
    logic        skip_valid_reg;
    logic        skip_valid_next;
    logic        skip_taken_reg;
    logic        skip_taken_next;
    logic        ext_rd_reg;
    logic        ext_rd_next;
    logic        ext_wr_reg;
    logic        ext_wr_next;
    logic [7:0]  ext_addr_reg;
    logic [7:0]  ext_addr_next;
    logic [7:0]  ext_wdata_reg;
    logic [7:0]  ext_wdata_next;

    // Decoded access, shared by all three request paths.
    logic        acc_rd;
    logic        acc_wr;
    logic [5:0]  acc_idx;
    logic [7:0]  acc_data;
    logic [7:0]  acc_bits;
    logic        dm_in_io;
    logic        dm_in_ext;
    logic        bit_op;
    logic        skip_op;
    logic [7:0]  bit_onehot;
    logic [7:0]  skip_byte;

    // Bits that software may store; everything else is reserved or hardware-owned.
    function automatic logic [7:0] rw_mask(input logic [5:0] idx);
        case (idx)
            iosd_pkg::PORT_B_DIRECTION, iosd_pkg::PORT_B_OUTPUT_LATCH,
            iosd_pkg::PORT_D_DIRECTION, iosd_pkg::PORT_D_OUTPUT_LATCH,
            iosd_pkg::GENERAL_SCRATCH_0, iosd_pkg::GENERAL_SCRATCH_1,
            iosd_pkg::GENERAL_SCRATCH_2, iosd_pkg::EEPROM_DATA,
            iosd_pkg::EEPROM_ADDRESS_LOW, iosd_pkg::EEPROM_ADDRESS_HIGH,
            iosd_pkg::TIMER0_COUNT, iosd_pkg::TIMER0_COMPARE_A,
            iosd_pkg::TIMER0_COMPARE_B, iosd_pkg::SERIAL_PERIPH_CONTROL,
            iosd_pkg::SERIAL_PERIPH_DATA:   rw_mask = iosd_pkg::MASK_FULL;
            iosd_pkg::PORT_C_DIRECTION,
            iosd_pkg::PORT_C_OUTPUT_LATCH:  rw_mask = iosd_pkg::MASK_PORT_C;
            iosd_pkg::EXTERNAL_IRQ_MASK:    rw_mask = iosd_pkg::RW_EXT_IRQ_MASK;
            iosd_pkg::EEPROM_CONTROL:       rw_mask = iosd_pkg::RW_EEPROM_CTRL;
            iosd_pkg::TIMER_PRESCALER_SYNC: rw_mask = iosd_pkg::RW_PRESCALER;
            iosd_pkg::TIMER0_CONTROL_A:     rw_mask = iosd_pkg::RW_TIMER0_A;
            iosd_pkg::TIMER0_CONTROL_B:     rw_mask = iosd_pkg::RW_TIMER0_B;
            iosd_pkg::SERIAL_PERIPH_STATUS: rw_mask = iosd_pkg::RW_SPI_STATUS;
            iosd_pkg::COMPARATOR_CTRL_STATUS: rw_mask = iosd_pkg::RW_COMPARATOR;
            default:                        rw_mask = 8'h00;
        endcase
    endfunction : rw_mask

    function automatic logic [7:0] w1c_mask(input logic [5:0] idx);
        case (idx)
            iosd_pkg::TIMER0_EVENT_FLAGS:     w1c_mask = iosd_pkg::W1C_TIMER0;
            iosd_pkg::TIMER1_EVENT_FLAGS:     w1c_mask = iosd_pkg::W1C_TIMER1;
            iosd_pkg::TIMER2_EVENT_FLAGS:     w1c_mask = iosd_pkg::W1C_TIMER2;
            iosd_pkg::PIN_CHANGE_FLAGS:       w1c_mask = iosd_pkg::W1C_PIN_CHANGE;
            iosd_pkg::EXTERNAL_IRQ_FLAGS:     w1c_mask = iosd_pkg::W1C_EXT_IRQ;
            iosd_pkg::COMPARATOR_CTRL_STATUS: w1c_mask = iosd_pkg::W1C_COMPARATOR;
            default:                          w1c_mask = 8'h00;
        endcase
    endfunction : w1c_mask

    // Read view of one location: stored bits, flags and live pin or peripheral state.
    function automatic logic [7:0] read_view(input logic [5:0] idx);
        logic [7:0] v;
        v = regs_reg[idx] & (rw_mask(idx) | w1c_mask(idx));
        case (idx)
            iosd_pkg::PORT_B_INPUT_PINS: v = pin_sync_reg[7:0];
            iosd_pkg::PORT_C_INPUT_PINS: v = pin_sync_reg[15:8] & iosd_pkg::MASK_PORT_C;
            iosd_pkg::PORT_D_INPUT_PINS: v = pin_sync_reg[23:16];
            iosd_pkg::SERIAL_PERIPH_STATUS:
                v[iosd_pkg::SPI_FLAG_LSB +: 2] = spi_sync_reg;
            iosd_pkg::COMPARATOR_CTRL_STATUS: v[iosd_pkg::CMP_OUT_BIT] = cmp_sync_reg;
            default: v = v;
        endcase
        read_view = v;
    endfunction : read_view

    // Request decode. Priority when several arrive together: short I/O, then
    // data space, then bit operations; the core issues one at a time.
    always_comb begin
        dm_in_io   = (dm_addr >= iosd_pkg::DM_IO_OFFSET) && (dm_addr < iosd_pkg::DM_EXT_BASE);
        dm_in_ext  = dm_addr >= iosd_pkg::DM_EXT_BASE;
        bit_op     = set_single_bit_instr || clear_single_bit_instr;
        skip_op    = skip_if_io_bit_one || skip_if_io_bit_zero;
        bit_onehot = 8'h01 << bit_sel;
        acc_rd     = 1'b0;
        acc_wr     = 1'b0;
        acc_idx    = io_addr;
        acc_data   = io_wdata;
        acc_bits   = iosd_pkg::MASK_FULL;
        if (io_rd || io_wr) begin
            acc_rd = io_rd;
            acc_wr = io_wr;
        end else if ((dm_rd || dm_wr) && dm_in_io) begin
            acc_rd   = dm_rd;
            acc_wr   = dm_wr;
            acc_idx  = 6'(dm_addr - iosd_pkg::DM_IO_OFFSET);
            acc_data = dm_wdata;
        end else if (bit_op) begin
            // A bit operation is a write that touches one lane only.
            acc_wr   = 1'b1;
            acc_idx  = {1'b0, bit_addr};
            acc_bits = bit_onehot;
            acc_data = set_single_bit_instr ? iosd_pkg::MASK_FULL : 8'h00;
        end
    end

    // Register file: writes, flag clears and hardware flag sets.
    always_comb begin
        logic [7:0] rw;
        logic [7:0] wc;
        rw = 8'h00;
        wc = 8'h00;
        for (int i = 0; i < iosd_pkg::IO_COUNT; i++) begin
            regs_next[i] = regs_reg[i];
            if (acc_wr && (acc_idx == 6'(i))) begin
                rw = rw_mask(6'(i)) & acc_bits;
                wc = w1c_mask(6'(i)) & acc_bits & acc_data;
                regs_next[i] = ((regs_reg[i] & ~rw) | (acc_data & rw)) & ~wc;
            end
        end
        // Sets come last so an event in the clearing cycle is kept.
        regs_next[iosd_pkg::TIMER0_EVENT_FLAGS] = regs_next[iosd_pkg::TIMER0_EVENT_FLAGS]
            | (tmr0_flag_set & iosd_pkg::W1C_TIMER0);
        regs_next[iosd_pkg::TIMER1_EVENT_FLAGS] = regs_next[iosd_pkg::TIMER1_EVENT_FLAGS]
            | (tmr1_flag_set & iosd_pkg::W1C_TIMER1);
        regs_next[iosd_pkg::TIMER2_EVENT_FLAGS] = regs_next[iosd_pkg::TIMER2_EVENT_FLAGS]
            | (tmr2_flag_set & iosd_pkg::W1C_TIMER2);
        regs_next[iosd_pkg::PIN_CHANGE_FLAGS] = regs_next[iosd_pkg::PIN_CHANGE_FLAGS]
            | (pin_change_set & iosd_pkg::W1C_PIN_CHANGE);
        regs_next[iosd_pkg::EXTERNAL_IRQ_FLAGS] = regs_next[iosd_pkg::EXTERNAL_IRQ_FLAGS]
            | (ext_irq_set & iosd_pkg::W1C_EXT_IRQ);
        regs_next[iosd_pkg::COMPARATOR_CTRL_STATUS] =
            regs_next[iosd_pkg::COMPARATOR_CTRL_STATUS]
            | ({8{cmp_flag_set}} & iosd_pkg::W1C_COMPARATOR);
    end

    // Answers and extended-area forwarding.
    always_comb begin
        // Extended loads are answered by the outer register logic, so none is raised here.
        rd_valid_next   = acc_rd || (dm_rd && !dm_in_io && !dm_in_ext && !(io_rd || io_wr));
        rdata_next      = acc_rd ? read_view(acc_idx) : 8'h00;
        skip_valid_next = skip_op && !(io_rd || io_wr || dm_rd || dm_wr || bit_op);
        skip_byte       = read_view({1'b0, bit_addr});
        skip_taken_next = skip_valid_next
            && (skip_byte[bit_sel] == skip_if_io_bit_one);
        ext_rd_next     = dm_rd && dm_in_ext && !(io_rd || io_wr);
        ext_wr_next     = dm_wr && dm_in_ext && !(io_rd || io_wr);
        ext_addr_next   = (ext_rd_next || ext_wr_next) ? dm_addr : ext_addr_reg;
        ext_wdata_next  = ext_wr_next ? dm_wdata : ext_wdata_reg;
    end

    always_ff @(posedge clk) begin
        pin_meta_reg <= port_pins;
        pin_sync_reg <= pin_meta_reg;
        spi_meta_reg <= spi_flags;
        spi_sync_reg <= spi_meta_reg;
        cmp_meta_reg <= cmp_output;
        cmp_sync_reg <= cmp_meta_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < iosd_pkg::IO_COUNT; i++) begin
                regs_reg[i] <= iosd_pkg::RESET_VALUE;
            end
            rdata_reg      <= 8'h00;
            rd_valid_reg   <= 1'b0;
            skip_valid_reg <= 1'b0;
            skip_taken_reg <= 1'b0;
            ext_rd_reg     <= 1'b0;
            ext_wr_reg     <= 1'b0;
            ext_addr_reg   <= 8'h00;
            ext_wdata_reg  <= 8'h00;
        end else begin
            for (int i = 0; i < iosd_pkg::IO_COUNT; i++) begin
                regs_reg[i] <= regs_next[i];
            end
            rdata_reg      <= rdata_next;
            rd_valid_reg   <= rd_valid_next;
            skip_valid_reg <= skip_valid_next;
            skip_taken_reg <= skip_taken_next;
            ext_rd_reg     <= ext_rd_next;
            ext_wr_reg     <= ext_wr_next;
            ext_addr_reg   <= ext_addr_next;
            ext_wdata_reg  <= ext_wdata_next;
        end
    end

    always_comb begin
        for (int i = 0; i < iosd_pkg::IO_COUNT; i++) begin
            io_image[i*8 +: 8] = regs_reg[i];
        end
    end

    assign rdata      = rdata_reg;
    assign rd_valid   = rd_valid_reg;
    assign skip_valid = skip_valid_reg;
    assign skip_taken = skip_taken_reg;
    assign ext_rd     = ext_rd_reg;
    assign ext_wr     = ext_wr_reg;
    assign ext_addr   = ext_addr_reg;
    assign ext_wdata  = ext_wdata_reg;

    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_io_write_scratch;
        io_wr && (io_addr == iosd_pkg::GENERAL_SCRATCH_1);
    endsequence

    sequence s_dm_read_scratch;
        dm_rd && !io_rd && !io_wr && (dm_addr == 8'h4a);
    endsequence

    AST_IO_SCRATCH_WRITE: assert property (s_io_write_scratch |=>
        regs_reg[iosd_pkg::GENERAL_SCRATCH_1] == $past(io_wdata))
        else $error("short write did not land");

    AST_DM_ALIAS_READ: assert property (s_dm_read_scratch ##0 !$rose(sys_rst) |=>
        rd_valid && (rdata == $past(regs_reg[iosd_pkg::GENERAL_SCRATCH_1])))
        else $error("data space alias read wrong");

    AST_BIT_SET_ONE: assert property (
        set_single_bit_instr && !io_rd && !io_wr && !dm_rd && !dm_wr
        && (bit_addr == 5'h1e) |=> regs_reg[iosd_pkg::GENERAL_SCRATCH_0][$past(bit_sel)])
        else $error("bit set did not set");

    AST_BIT_ONLY: assert property (
        clear_single_bit_instr && !io_rd && !io_wr && !dm_rd && !dm_wr
        && (bit_addr == 5'h1e) |=> ((regs_reg[iosd_pkg::GENERAL_SCRATCH_0]
        ^ $past(regs_reg[iosd_pkg::GENERAL_SCRATCH_0])) & ~($past(bit_onehot))) == 8'h00)
        else $error("bit clear touched other bits");

    AST_FLAG_W1C: assert property (
        io_wr && (io_addr == iosd_pkg::EXTERNAL_IRQ_FLAGS) && (ext_irq_set == 8'h00)
        |=> regs_reg[iosd_pkg::EXTERNAL_IRQ_FLAGS]
        == ($past(regs_reg[iosd_pkg::EXTERNAL_IRQ_FLAGS]) & ~$past(io_wdata)))
        else $error("flag write-one-to-clear wrong");

    AST_FLAG_SET_WINS: assert property (
        ext_irq_set[0] |=> regs_reg[iosd_pkg::EXTERNAL_IRQ_FLAGS][0])
        else $error("flag event lost");

    AST_SKIP_TEST: assert property (
        skip_if_io_bit_one && !io_rd && !io_wr && !dm_rd && !dm_wr && !bit_op
        && (bit_addr == 5'h1e) && !sys_rst |=> skip_valid
        && (skip_taken == $past(regs_reg[iosd_pkg::GENERAL_SCRATCH_0][bit_sel])))
        else $error("skip test wrong");

    AST_EXT_ONLY_DM: assert property (
        (ext_rd || ext_wr) |-> $past(dm_rd || dm_wr) && ($past(dm_addr) >= 8'h60))
        else $error("extended strobe without load or store");

    AST_RESERVED_ZERO: assert property (
        io_rd && (io_addr == 6'h2f) |=> rd_valid && (rdata == 8'h00))
        else $error("reserved location not zero");

    sequence s_ext_store;
        dm_wr && !io_rd && !io_wr && (dm_addr >= iosd_pkg::DM_EXT_BASE);
    endsequence

    sequence s_ext_load;
        dm_rd && !io_rd && !io_wr && (dm_addr >= iosd_pkg::DM_EXT_BASE);
    endsequence

    AST_EXT_STORE_FWD: assert property (s_ext_store |=>
        ext_wr && (ext_addr == $past(dm_addr)) && (ext_wdata == $past(dm_wdata)))
        else $error("extended store not forwarded");

    AST_EXT_LOAD_QUIET: assert property (s_ext_load |=>
        ext_rd && !rd_valid)
        else $error("extended load answered locally");

    AST_DM_LOW_ZERO: assert property (
        dm_rd && !io_rd && !io_wr && (dm_addr < iosd_pkg::DM_IO_OFFSET)
        |=> rd_valid && (rdata == 8'h00))
        else $error("load below the I/O window not zero");

    AST_BIT_CLEAR_KEEPS_FLAG: assert property (
        clear_single_bit_instr && !set_single_bit_instr && !io_rd && !io_wr && !dm_rd
        && !dm_wr && (bit_addr == 5'h1c) && (ext_irq_set == 8'h00)
        |=> regs_reg[iosd_pkg::EXTERNAL_IRQ_FLAGS]
        == $past(regs_reg[iosd_pkg::EXTERNAL_IRQ_FLAGS]))
        else $error("bit clear changed a flag");

    AST_SKIP_ZERO_TEST: assert property (
        skip_if_io_bit_zero && !skip_if_io_bit_one && !io_rd && !io_wr && !dm_rd && !dm_wr
        && !bit_op && (bit_addr == 5'h1e) |=> skip_valid
        && (skip_taken != $past(regs_reg[iosd_pkg::GENERAL_SCRATCH_0][bit_sel])))
        else $error("skip on zero wrong");

    AST_IO_READ_ANSWER: assert property (
        io_rd |=> rd_valid)
        else $error("short read not answered");

    AST_IO_WRITE_QUIET: assert property (
        io_wr && !io_rd |=> !rd_valid)
        else $error("short write raised a read answer");

endmodule : iosd_io_space

// ===== tb/iosd_core_model.sv
`timescale 1ns/1ps
// Core side of the register space: one request per call, held for exactly one cycle.
module iosd_core_model (
    // Clock
    input  wire logic       clk,
    // Request strobes, address and data
    output logic [7:0]      req,
    output logic [7:0]      addr,
    output logic [7:0]      wdata
);
    initial begin
        req   = 8'h00;
        addr  = 8'h00;
        wdata = 8'h00;
    end

    // Idle lines show the inverse of the last value so a design that samples them late is caught.
    task automatic issue(input int k, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req   <= 8'h01 << k;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        req   <= 8'h00;
        addr  <= ~a;
        wdata <= ~d;
    endtask : issue
endmodule : iosd_core_model

// ===== tb/io_space_address_decode_tb.sv
`timescale 1ns/1ps
module io_space_address_decode_tb;
    logic         clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic [7:0]   req, addr, wdata, rdata, ext_addr, ext_wdata;
    logic         rd_valid, skip_valid, skip_taken, ext_rd, ext_wr;
    logic [23:0]  pins;
    logic [7:0]   fset = 8'h00;
    logic         cset = 1'b0;
    logic         cmp_o = 1'b1;
    logic [1:0]   spi = 2'b10;
    logic [511:0] io_image;
    logic [7:0]   shadow [64];
    logic [7:0]   rd_q [$];
    logic         sk_q [$];
    logic [15:0]  ex_q [$];
    int           fails = 0;
    int           cmp_count = 0;
    int           seed = 32'h75cd;

    initial forever #12.5 clk = ~clk;

    iosd_core_model i_core (.clk(clk), .req(req), .addr(addr), .wdata(wdata));

    iosd_io_space i_dut (
        .clk(clk), .sys_rst(sys_rst),
        .io_rd(req[0]), .io_wr(req[1]), .io_addr(addr[5:0]), .io_wdata(wdata),
        .dm_rd(req[2]), .dm_wr(req[3]), .dm_addr(addr), .dm_wdata(wdata),
        .set_single_bit_instr(req[4]), .clear_single_bit_instr(req[5]),
        .skip_if_io_bit_one(req[6]), .skip_if_io_bit_zero(req[7]),
        .bit_addr(addr[4:0]), .bit_sel(wdata[2:0]),
        .rdata(rdata), .rd_valid(rd_valid), .skip_valid(skip_valid), .skip_taken(skip_taken),
        .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .port_pins(pins), .tmr0_flag_set(fset), .tmr1_flag_set(fset), .tmr2_flag_set(fset),
        .pin_change_set(fset), .ext_irq_set(fset), .cmp_flag_set(cset), .cmp_output(cmp_o),
        .spi_flags(spi), .io_image(io_image)
    );

    function automatic logic [7:0] wm(input logic [5:0] a);
        case (a)
            6'h07, 6'h08: return 8'h7f;
            6'h1d: return 8'h03;
            6'h1f: return 8'h3f;
            6'h23: return 8'h83;
            6'h24: return 8'hf3;
            6'h25, 6'h30: return 8'hcf;
            6'h2d: return 8'h01;
            6'h04, 6'h05, 6'h0a, 6'h0b, 6'h1e, 6'h20, 6'h21, 6'h22, 6'h26, 6'h27, 6'h28,
            6'h2a, 6'h2b, 6'h2c, 6'h2e: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction : wm

    function automatic logic [7:0] w1c(input logic [5:0] a);
        case (a)
            6'h15, 6'h17, 6'h1b: return 8'h07;
            6'h16: return 8'h27;
            6'h1c: return 8'h03;
            6'h30: return 8'h10;
            default: return 8'h00;
        endcase
    endfunction : w1c

    function automatic logic [7:0] view(input logic [5:0] a);
        case (a)
            6'h03: return pins[7:0];
            6'h06: return {1'b0, pins[14:8]};
            6'h09: return pins[23:16];
            6'h2d: return {spi, 5'h00, shadow[a][0]};
            6'h30: return shadow[a] | {2'b00, cmp_o, 5'h00};
            default: return shadow[a];
        endcase
    endfunction : view

    // Request codes: 0 io read, 1 io write, 2 load, 3 store, 4 bit set, 5 bit clear, 6/7 skips.
    task automatic op(input int k, input logic [7:0] a, input logic [7:0] d);
        logic [5:0] r;
        logic [7:0] b;
        logic [7:0] v;
        r = (k == 2 || k == 3) ? 6'(a - 8'h20) : a[5:0];
        b = 8'h01 << d[2:0];
        v = view(r);
        case (k)
            0, 2: begin
                if (k == 2 && a >= 8'h60) ex_q.push_back({a, 8'h00});
                else rd_q.push_back((k == 2 && a < 8'h20) ? 8'h00 : v);
            end
            1, 3: begin
                if (k == 3 && a >= 8'h60) ex_q.push_back({a, d});
                else if (k == 1 || a >= 8'h20)
                    shadow[r] = (d & wm(r)) | (shadow[r] & w1c(r) & ~d);
            end
            4: shadow[r] = ((w1c(r) & b) != 0) ? (shadow[r] & ~b) : (shadow[r] | (b & wm(r)));
            5: shadow[r] = shadow[r] & ~(b & wm(r) & ~w1c(r));
            default: sk_q.push_back(v[d[2:0]] == (k == 6));
        endcase
        i_core.issue(k, a, d);
    endtask : op

    task automatic pulse_flags();
        @(posedge clk);
        fset <= 8'hff;
        cset <= 1'b1;
        @(posedge clk);
        fset <= 8'h00;
        cset <= 1'b0;
        foreach (shadow[i]) shadow[i] = shadow[i] | w1c(6'(i));
    endtask : pulse_flags

    task automatic note(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : note

    task automatic extra(input logic [15:0] got);
        fails++;
        $display("ERROR %0t got %h expected %h", $time, got, 16'h0000);
    endtask : extra

    task automatic cmp_rd();
        if (rd_q.size() == 0) extra({8'h00, rdata});
        else note({8'h00, rdata}, {8'h00, rd_q.pop_front()});
    endtask : cmp_rd

    task automatic cmp_skip();
        if (sk_q.size() == 0) extra({15'h0000, skip_taken});
        else note({15'h0000, skip_taken}, {15'h0000, sk_q.pop_front()});
    endtask : cmp_skip

    task automatic cmp_ext();
        if (ex_q.size() == 0) extra({ext_addr, ext_wdata});
        else note({ext_addr, ext_wr ? ext_wdata : 8'h00}, ex_q.pop_front());
    endtask : cmp_ext

    task automatic cmp_image(input int i);
        note({8'h00, io_image[i*8 +: 8]}, {8'h00, shadow[i]});
    endtask : cmp_image

    // Results are sampled mid-cycle, well clear of the edge that launches them.
    always @(negedge clk) begin
        if (sys_rst === 1'b0) begin
            if (rd_valid !== 1'b0) cmp_rd();
            if (skip_valid !== 1'b0) cmp_skip();
            if (ext_rd !== 1'b0 || ext_wr !== 1'b0) cmp_ext();
        end
    end

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic drain(input string name);
        int n = 0;
        while (rd_q.size() + sk_q.size() + ex_q.size() != 0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (rd_q.size() + sk_q.size() + ex_q.size() != 0) begin
            fails++;
            $display("ERROR %0t results missing %h %h", $time, 8'h00, 8'h01);
            summarize();
        end
        repeat (3) @(posedge clk);
        $display("test %s done", name);
    endtask : drain

    initial begin
        logic [2:0] b;
        foreach (shadow[i]) shadow[i] = 8'h00;
        pins = 24'($random(seed));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 64; a++) op(0, 8'(a), 8'h00);
        drain("reset_map");
        for (int a = 0; a < 64; a++) op(1, 8'(a), 8'($random(seed)));
        for (int a = 0; a < 64; a++) op(2, 8'(a + 32), 8'h00);
        op(3, 8'h3e, 8'h3c);
        op(0, 8'h1e, 8'h00);
        op(3, 8'h10, 8'hff);
        op(2, 8'h10, 8'h00);
        drain("map_offset");
        pulse_flags();
        for (int a = 21; a < 29; a++) op(0, 8'(a), 8'h00);
        op(4, 8'h1c, 8'h00);
        op(5, 8'h1c, 8'h01);
        op(0, 8'h1c, 8'h00);
        op(1, 8'h15, 8'h00);
        op(1, 8'h16, 8'h21);
        op(2, 8'h35, 8'h00);
        op(2, 8'h36, 8'h00);
        op(1, 8'h30, 8'h10);
        op(0, 8'h30, 8'h00);
        drain("flags");
        for (int i = 0; i < 32; i++) begin
            b = 3'($random(seed));
            op(4, 8'(i), 8'(b));
            op(6, 8'(i), 8'(b));
            op(5, 8'(i), 8'(b));
            op(7, 8'(i), 8'(b));
            op(0, 8'(i), 8'h00);
        end
        drain("bit_ops");
        op(3, 8'h60, 8'ha5);
        op(3, 8'hff, 8'h5a);
        op(2, 8'h80, 8'h00);
        op(2, 8'h5f, 8'h00);
        drain("extended");
        foreach (shadow[i]) cmp_image(i);
        summarize();
    end

    // A hang is cut short at 2 ms, about a hundred times the length of a normal run.
    initial begin
        #2000000;
        fails++;
        $display("ERROR %0t run limit %h %h", $time, 8'h00, 8'h01);
        summarize();
    end
endmodule : io_space_address_decode_tb
